// >>> verilog/spi_port_cfg.svh
// Constants for the serial port: timing, field positions and reset values.
`ifndef SPI_PORT_CFG_SVH
`define SPI_PORT_CFG_SVH
// System clock and highest master bit rate, in kHz
`define SYS_CLK_KHZ 40000
`define MAX_SCK_KHZ 12500
// Shortest SCK half period in system clocks, rounded up
`define MIN_HALF_CYC ((`SYS_CLK_KHZ + 2 * `MAX_SCK_KHZ - 1) / (2 * `MAX_SCK_KHZ))
`define BYTE_W 8
`define RATE_W 8
`define HALF_W 9
`define CNT_W 4
`define LAST_BIT 4'h7
// Event flag positions within the flag vector
`define FLAG_DONE 3
`define FLAG_WRITE_COLLISION_FLAG 2
`define FLAG_MODE_FAULT_FLAG 1
`define FLAG_OVR 0
`define FLAGS_RST 4'h0
`define RATE_RST 8'h00
`define SEL_HI_RST 1'b0
`define SEL_LO_RST 1'b1
`endif

// >>> verilog/spi_port_pkg.sv
// Types for the serial port: master sequencer states and the state record.
`default_nettype none
package spi_port_pkg;
  `include "spi_port_cfg.svh"
  typedef enum logic [1:0] {M_IDLE = 2'b00, M_RUN = 2'b01} mst_state_t;
  typedef struct packed {
    logic sck_m, sck_s, sck_p;
    logic mosi_m, mosi_s;
    logic miso_m, miso_s;
    logic nss_m, nss_s, nss_p;
    logic master_en, port_en, sel_hi, sel_lo, cpha, cpol;
    logic [`RATE_W-1:0] rate;
    logic [3:0] flags;
    logic [`BYTE_W-1:0] tx_buf;
    logic tx_full;
    logic [`BYTE_W-1:0] sh;
    logic sh_empty;
    logic [`BYTE_W-1:0] rx_buf;
    logic rx_full;
    mst_state_t mst;
    logic [`HALF_W-1:0] cnt;
    logic half;
    logic [`CNT_W-1:0] bits;
    logic sck_q;
  } state_t;
endpackage
`default_nettype wire

// >>> verilog/spi_port.sv
// Serial port, master or slave, 3-wire or 4-wire, with sticky event flags.
`default_nettype none
`include "spi_port_cfg.svh"
module spi_port import spi_port_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Control writes
  input wire logic ctrl_wr,
  input wire logic master_enable_in,
  input wire logic port_enable_in,
  input wire logic select_mode_high_in,
  input wire logic select_mode_low_in,
  input wire logic clock_phase_in,
  input wire logic clock_polarity_in,
  input wire logic rate_wr,
  input wire logic [`RATE_W-1:0] rate_wdata,
  input wire logic [3:0] flag_clr,
  // Data window
  input wire logic dat_wr,
  input wire logic [`BYTE_W-1:0] dat_wdata,
  input wire logic dat_rd,
  output logic [`BYTE_W-1:0] rx_data,
  // Status
  output logic master_enable_bit,
  output logic port_enable_bit,
  output logic select_mode_high_bit,
  output logic select_mode_low_bit,
  output logic clock_phase_bit,
  output logic clock_polarity_bit,
  output logic transfer_done_flag,
  output logic write_collision_flag,
  output logic mode_fault_flag,
  output logic rx_overrun_flag,
  output logic tx_buffer_empty,
  output logic rx_buffer_full,
  output logic busy,
  // Pins
  input wire logic sck_in,
  output logic sck_out,
  output logic sck_oe_n,
  input wire logic mosi_in,
  output logic mosi_out,
  output logic mosi_oe_n,
  input wire logic miso_in,
  output logic miso_out,
  output logic miso_oe_n,
  input wire logic slave_select_n_in,
  output logic slave_select_n_out,
  output logic slave_select_n_oe_n
);

  state_t q, n;

  // Half period of master SCK in system clocks, never below the rate cap
  function automatic logic [`HALF_W-1:0] half_len(input logic [`RATE_W-1:0] r);
    logic [`HALF_W-1:0] h;
    h = {1'b0, r} + `HALF_W'(1);
    if (h < `HALF_W'(`MIN_HALF_CYC)) h = `HALF_W'(`MIN_HALF_CYC);
    return h;
  endfunction

  function automatic state_t rst_state();
    state_t s;
    s = '0;
    s.nss_m = 1'b1;
    s.nss_s = 1'b1;
    s.nss_p = 1'b1;
    s.sel_hi = `SEL_HI_RST;
    s.sel_lo = `SEL_LO_RST;
    s.rate = `RATE_RST;
    s.flags = `FLAGS_RST;
    s.sh_empty = 1'b1;
    s.mst = M_IDLE;
    return s;
  endfunction

  logic master_on, slave_on, multi_mode, four_wire_slave, selected;
  logic sck_edge, sample_edge, nss_fall, slv_done, fault_now;
  logic [`HALF_W-1:0] hl;

  assign master_on = q.port_en & q.master_en;
  assign slave_on = q.port_en & ~q.master_en;
  assign multi_mode = ~q.sel_hi & q.sel_lo;
  assign four_wire_slave = slave_on & multi_mode;
  // Three-wire slave is always selected; select line ignored there
  assign selected = slave_on & ~(multi_mode & q.nss_s);
  assign sck_edge = q.sck_s ^ q.sck_p;
  // Phase 0 latches on the edge leaving idle, phase 1 on the return
  assign sample_edge = selected & sck_edge
      & (q.cpha ? (q.sck_s == q.cpol) : (q.sck_s != q.cpol));
  assign nss_fall = q.nss_p & ~q.nss_s;
  assign slv_done = sample_edge & (q.bits == `LAST_BIT);
  assign fault_now = master_on & multi_mode & ~q.nss_s;
  assign hl = half_len(q.rate);

  always_comb begin
    n = q;
    // Two-stage synchronisers; SCK and select keep a third stage for edge detection
    n.sck_m = sck_in;
    n.sck_s = q.sck_m;
    n.sck_p = q.sck_s;
    n.mosi_m = mosi_in;
    n.mosi_s = q.mosi_m;
    n.miso_m = miso_in;
    n.miso_s = q.miso_m;
    n.nss_m = slave_select_n_in;
    n.nss_s = q.nss_m;
    n.nss_p = q.nss_s;
    if (ctrl_wr) begin
      n.master_en = master_enable_in;
      n.port_en = port_enable_in;
      n.sel_hi = select_mode_high_in;
      n.sel_lo = select_mode_low_in;
      n.cpha = clock_phase_in;
      n.cpol = clock_polarity_in;
    end
    if (rate_wr) n.rate = rate_wdata;
    n.flags = q.flags & ~flag_clr;
    if (dat_rd) n.rx_full = 1'b0;
    if (dat_wr) begin
      if (q.tx_full) begin
        n.flags[`FLAG_WRITE_COLLISION_FLAG] = 1'b1;
      end else begin
        n.tx_buf = dat_wdata;
        n.tx_full = 1'b1;
      end
    end
    if (!q.port_en) begin
      // Disabling restarts the byte framing
      n.mst = M_IDLE;
      n.bits = '0;
      n.sh_empty = 1'b1;
    end else if (q.master_en) begin
      case (q.mst)
        M_IDLE: begin
          if (n.tx_full) begin
            n.sh = n.tx_buf;
            n.tx_full = 1'b0;
            n.mst = M_RUN;
            n.cnt = '0;
            n.half = 1'b0;
            n.bits = '0;
          end
        end
        M_RUN: begin
          if (q.cnt == hl - `HALF_W'(1)) begin
            n.cnt = '0;
            n.half = ~q.half;
            if (q.half) begin
              // Last system clock of the bit samples the slave's data
              n.sh = {q.sh[`BYTE_W-2:0], q.miso_s};
              n.bits = q.bits + `CNT_W'(1);
              if (q.bits == `LAST_BIT) begin
                n.bits = '0;
                n.rx_buf = {q.sh[`BYTE_W-2:0], q.miso_s};
                n.rx_full = 1'b1;
                n.flags[`FLAG_DONE] = 1'b1;
                if (n.tx_full) begin
                  n.sh = n.tx_buf;
                  n.tx_full = 1'b0;
                end else begin
                  n.mst = M_IDLE;
                end
              end
            end
          end else begin
            n.cnt = q.cnt + `HALF_W'(1);
          end
        end
        default: n.mst = M_IDLE;
      endcase
    end else begin
      n.mst = M_IDLE;
      if (sample_edge) begin
        // Mid-bit latch of MOSI; no transfer starts from this side
        n.sh = {q.sh[`BYTE_W-2:0], q.mosi_s};
        n.sh_empty = 1'b0;
        n.bits = q.bits + `CNT_W'(1);
        if (slv_done) begin
          n.bits = '0;
          n.flags[`FLAG_DONE] = 1'b1;
          if (q.rx_full) begin
            n.flags[`FLAG_OVR] = 1'b1;
          end else begin
            n.rx_buf = {q.sh[`BYTE_W-2:0], q.mosi_s};
            n.rx_full = 1'b1;
          end
          n.sh_empty = ~n.tx_full;
          if (n.tx_full) begin
            n.sh = n.tx_buf;
            n.tx_full = 1'b0;
          end
        end
      end else if (q.sh_empty && n.tx_full) begin
        n.sh = n.tx_buf;
        n.sh_empty = 1'b0;
        n.tx_full = 1'b0;
      end
      if (four_wire_slave && nss_fall) n.bits = '0;
    end
    if (fault_now) begin
      // Fault wins over a software enable in the same cycle
      n.master_en = 1'b0;
      n.port_en = 1'b0;
      n.flags[`FLAG_MODE_FAULT_FLAG] = 1'b1;
      n.mst = M_IDLE;
    end
    n.sck_q = (n.mst == M_RUN) ? (n.cpol ^ (n.half ^ n.cpha)) : n.cpol;
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      q <= rst_state();
    end else begin
      q <= n;
    end
  end

  assign rx_data = q.rx_buf;
  assign master_enable_bit = q.master_en;
  assign port_enable_bit = q.port_en;
  assign select_mode_high_bit = q.sel_hi;
  assign select_mode_low_bit = q.sel_lo;
  assign clock_phase_bit = q.cpha;
  assign clock_polarity_bit = q.cpol;
  assign transfer_done_flag = q.flags[`FLAG_DONE];
  assign write_collision_flag = q.flags[`FLAG_WRITE_COLLISION_FLAG];
  assign mode_fault_flag = q.flags[`FLAG_MODE_FAULT_FLAG];
  assign rx_overrun_flag = q.flags[`FLAG_OVR];
  assign tx_buffer_empty = ~q.tx_full;
  assign rx_buffer_full = q.rx_full;
  assign busy = (q.mst == M_RUN) | (slave_on & (q.bits != '0));
  assign sck_out = q.sck_q;
  assign sck_oe_n = ~master_on;
  assign mosi_out = q.sh[`BYTE_W-1];
  assign mosi_oe_n = ~master_on;
  assign miso_out = q.sh[`BYTE_W-1];
  assign miso_oe_n = ~selected;
  assign slave_select_n_out = q.sel_lo;
  assign slave_select_n_oe_n = ~q.sel_hi;

  property p_mode_fault;
    @(posedge clk) disable iff (!resetn)
    fault_now |=> !q.master_en && !q.port_en && q.flags[`FLAG_MODE_FAULT_FLAG];
  endproperty
  a_mode_fault: assert property (p_mode_fault) else $error("mode fault did not disable");

  property p_collision;
    @(posedge clk) disable iff (!resetn)
    dat_wr && q.tx_full |=> q.flags[`FLAG_WRITE_COLLISION_FLAG] && (q.tx_buf == $past(q.tx_buf));
  endproperty
  a_collision: assert property (p_collision) else $error("collision not flagged");

  property p_master_start;
    @(posedge clk) disable iff (!resetn)
    master_on && !fault_now && q.mst == M_IDLE && dat_wr && !q.tx_full
      |=> q.mst == M_RUN && q.sh == $past(dat_wdata) && !q.tx_full;
  endproperty
  a_master_start: assert property (p_master_start) else $error("master did not start");

  property p_sck_idle;
    @(posedge clk) disable iff (!resetn)
    q.mst == M_IDLE |-> sck_out == q.cpol;
  endproperty
  a_sck_idle: assert property (p_sck_idle) else $error("sck not at idle level");

  property p_flag_sticky;
    @(posedge clk) disable iff (!resetn)
    q.flags[`FLAG_DONE] && !flag_clr[`FLAG_DONE] |=> q.flags[`FLAG_DONE];
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("done flag lost");

  property p_overrun;
    @(posedge clk) disable iff (!resetn)
    slv_done && q.rx_full && !fault_now
      |=> q.flags[`FLAG_OVR] && (q.rx_buf == $past(q.rx_buf)) && q.flags[`FLAG_DONE];
  endproperty
  a_overrun: assert property (p_overrun) else $error("overrun mishandled");

  property p_select_out;
    @(posedge clk) disable iff (!resetn)
    q.sel_hi |-> !slave_select_n_oe_n && (slave_select_n_out == q.sel_lo);
  endproperty
  a_select_out: assert property (p_select_out) else $error("select output wrong");

  property p_miso_release;
    @(posedge clk) disable iff (!resetn)
    (!q.port_en || q.master_en || (multi_mode && q.nss_s)) |-> miso_oe_n;
  endproperty
  a_miso_release: assert property (p_miso_release) else $error("miso driven");

  property p_disable_clears;
    @(posedge clk) disable iff (!resetn)
    !q.port_en ##1 !q.port_en |-> q.bits == '0 && q.mst == M_IDLE;
  endproperty
  a_disable_clears: assert property (p_disable_clears) else $error("counter not cleared");

  property p_nss_fall;
    @(posedge clk) disable iff (!resetn)
    four_wire_slave && nss_fall && !fault_now |=> q.bits == '0;
  endproperty
  a_nss_fall: assert property (p_nss_fall) else $error("select fall kept count");

endmodule
`default_nettype wire

// >>> test/spi_peer.sv
// Link peer: responds as a slave to a master port, or drives a slave port as master.
`default_nettype none
module spi_peer (
  // Resolved lines
  input wire logic sck,
  input wire logic mosi,
  input wire logic miso,
  // Mode shared with the port
  input wire logic cpol,
  input wire logic cpha,
  // Peer drives
  output logic p_sck,
  output logic p_mosi,
  output logic p_miso,
  output logic p_nss_n
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] resp = 8'h00;
  logic [7:0] shin = 8'h00;
  logic armed = 1'b0;
  int lat = 0;
  logic [7:0] rx_q[$];
  initial begin
    {p_sck, p_mosi, p_miso, p_nss_n} = 4'h1;
  end
  task automatic arm(input logic [7:0] r);
    resp = r;
    lat = 0;
    rx_q.delete();
    armed = 1'b1;
    p_miso = r[7];
  endtask
  // Counts restart on arm so an idle-level change on reconfigure is not taken as an edge
  always @(sck) begin
    if (armed) begin
      if ((sck != cpol) ^ cpha) begin
        shin = {shin[6:0], mosi};
        lat = (lat + 1) % 8;
        if (lat == 0) rx_q.push_back(shin);
      end else begin
        p_miso = resp[7 - lat];
      end
    end
  end
  // Half period 150 ns keeps the bit rate under a tenth of the port clock
  task automatic mxfer(input logic [7:0] tx, output logic [7:0] rx);
    armed = 1'b0;
    p_sck = cpol;
    #53;
    p_nss_n = 1'b0;
    #100;
    for (int i = 7; i >= 0; i--) begin
      if (cpha) p_sck = ~cpol;
      p_mosi = tx[i];
      #150;
      p_sck = cpha ? cpol : ~cpol;
      rx[i] = miso;
      #150;
      if (!cpha) p_sck = cpol;
    end
    #150;
    p_nss_n = 1'b1;
    p_mosi = ~p_mosi;
  endtask
endmodule
`default_nettype wire

// >>> test/tb_top.sv
// Bench for the serial port: master and slave transfers, select modes, event flags.
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic ctrl_wr, m_en, p_en, s_hi, s_lo, pha, pol, rate_wr, dat_wr, dat_rd;
  logic [7:0] rate_wdata, dat_wdata, rx_data, a, b, r, got;
  logic [3:0] flag_clr;
  logic mst_b, en_b, hi_b, lo_b, pha_b, pol_b, done_f, write_collision_flag_f, mode_fault_flag_f, ovr_f, txe, rxf, busy_b;
  logic sck_out, sck_oe_n, mosi_out, mosi_oe_n, miso_out, miso_oe_n, ss_out, ss_oe_n;
  logic p_sck, p_mosi, p_miso, p_nss_n;
  logic [7:0] exp_q[$];
  int fail_count = 0;
  int samples_checked = 0;
  int seed = 58165;
  int cyc = 0;
  wire sck_w = sck_oe_n ? p_sck : sck_out;
  wire mosi_w = mosi_oe_n ? p_mosi : mosi_out;
  wire miso_w = miso_oe_n ? p_miso : miso_out;
  wire ss_w = ss_oe_n ? p_nss_n : ss_out;
  always #12.5 clk = ~clk;
  spi_port u_dut (.clk(clk), .resetn(resetn), .ctrl_wr(ctrl_wr), .master_enable_in(m_en),
    .port_enable_in(p_en), .select_mode_high_in(s_hi), .select_mode_low_in(s_lo),
    .clock_phase_in(pha), .clock_polarity_in(pol), .rate_wr(rate_wr), .rate_wdata(rate_wdata),
    .flag_clr(flag_clr), .dat_wr(dat_wr), .dat_wdata(dat_wdata), .dat_rd(dat_rd),
    .rx_data(rx_data), .master_enable_bit(mst_b), .port_enable_bit(en_b),
    .select_mode_high_bit(hi_b), .select_mode_low_bit(lo_b), .clock_phase_bit(pha_b),
    .clock_polarity_bit(pol_b), .transfer_done_flag(done_f), .write_collision_flag(write_collision_flag_f),
    .mode_fault_flag(mode_fault_flag_f), .rx_overrun_flag(ovr_f), .tx_buffer_empty(txe),
    .rx_buffer_full(rxf), .busy(busy_b), .sck_in(sck_w), .sck_out(sck_out), .sck_oe_n(sck_oe_n),
    .mosi_in(mosi_w), .mosi_out(mosi_out), .mosi_oe_n(mosi_oe_n), .miso_in(miso_w),
    .miso_out(miso_out), .miso_oe_n(miso_oe_n), .slave_select_n_in(ss_w),
    .slave_select_n_out(ss_out), .slave_select_n_oe_n(ss_oe_n));
  spi_peer u_peer (.sck(sck_w), .mosi(mosi_w), .miso(miso_w), .cpol(pol), .cpha(pha),
    .p_sck(p_sck), .p_mosi(p_mosi), .p_miso(p_miso), .p_nss_n(p_nss_n));
  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    samples_checked++;
    if (seen !== want) begin
      fail_count++;
      $display("unexpected at %0t: got %0h want %0h", $time, seen, want);
    end
  endtask
  task automatic results;
    $display("mismatches %0d, comparisons %0d", fail_count, samples_checked);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      fail_count++;
      results();
    end
  end
  task automatic cfg(input logic m, e, h, l, ph, po);
    @(posedge clk);
    {ctrl_wr, m_en, p_en, s_hi, s_lo, pha, pol} <= {1'b1, m, e, h, l, ph, po};
    @(posedge clk);
    ctrl_wr <= 1'b0;
    repeat (3) @(negedge clk);
  endtask
  task automatic wr(input logic [7:0] d);
    @(posedge clk);
    {dat_wr, dat_wdata} <= {1'b1, d};
    @(posedge clk);
    dat_wr <= 1'b0;
  endtask
  // Flag clear and data read pulses share one strobe task
  task automatic ctl(input logic [3:0] f, input logic rd);
    @(posedge clk);
    {flag_clr, dat_rd} <= {f, rd};
    @(posedge clk);
    {flag_clr, dat_rd} <= 5'h00;
    @(negedge clk);
  endtask
  task automatic wait_done;
    int n;
    n = 0;
    while (done_f !== 1'b1 && n < 3000) begin
      @(negedge clk);
      n++;
    end
    // A transfer that never ends counts as a mismatch
    if (n >= 3000) fail_count++;
  endtask
  initial begin
    {ctrl_wr, m_en, p_en, s_hi, s_lo, pha, pol, rate_wr, dat_wr, dat_rd} = 10'h000;
    {rate_wdata, dat_wdata, flag_clr} = 20'h00000;
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    @(negedge clk);
    chk({mst_b, en_b, hi_b, lo_b, pha_b, pol_b}, 8'h04);
    chk({done_f, write_collision_flag_f, mode_fault_flag_f, ovr_f, txe, rxf}, 8'h02);
    chk({sck_oe_n, mosi_oe_n, miso_oe_n, ss_oe_n}, 8'h0F);
    for (int m = 0; m < 4; m++) begin
      cfg(1'b1, 1'b0, 1'b0, 1'b0, m[1], m[0]);
      cfg(1'b1, 1'b1, 1'b0, 1'b0, m[1], m[0]);
      @(posedge clk);
      {rate_wr, rate_wdata} <= {1'b1, 8'($random(seed)) & 8'h03};
      @(posedge clk);
      rate_wr <= 1'b0;
      r = 8'($random(seed));
      a = 8'($random(seed));
      u_peer.arm(r);
      wr(a);
      @(negedge clk);
      chk({busy_b, txe}, 2'b11);
      wait_done();
      repeat (10) @(negedge clk);
      chk(rx_data, r);
      chk({rxf, busy_b}, 2'b10);
      chk(u_peer.rx_q.pop_front(), a);
      chk({done_f, ss_oe_n, sck_out, pha_b, pol_b}, {1'b1, 1'b1, m[0], m[1], m[0]});
      ctl(4'h8, 1'b0);
      chk(done_f, 1'b0);
    end
    a = 8'($random(seed));
    b = 8'($random(seed));
    u_peer.arm(8'h3C);
    wr(a);
    wr(b);
    wr(8'h5A);
    @(negedge clk);
    chk({write_collision_flag_f, txe}, 8'h02);
    exp_q = {a, b};
    wait_done();
    ctl(4'h8, 1'b0);
    wait_done();
    chk(u_peer.rx_q.size(), 8'h02);
    foreach (exp_q[i]) chk(u_peer.rx_q[i], exp_q[i]);
    ctl(4'hC, 1'b1);
    cfg(1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
    cfg(1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0);
    u_peer.p_nss_n = 1'b0;
    repeat (10) @(negedge clk);
    chk({mst_b, en_b, mode_fault_flag_f, sck_oe_n}, 8'h03);
    u_peer.p_nss_n = 1'b1;
    ctl(4'h2, 1'b0);
    chk(mode_fault_flag_f, 1'b0);
    for (int l = 0; l < 2; l++) begin
      cfg(1'b1, 1'b1, 1'b1, l[0], 1'b0, 1'b0);
      chk({ss_oe_n, ss_out, hi_b, lo_b}, {1'b0, l[0], 1'b1, l[0]});
    end
    for (int m = 0; m < 4; m++) begin
      cfg(1'b0, 1'b0, 1'b0, 1'b1, m[1], m[0]);
      cfg(1'b0, 1'b1, 1'b0, 1'b1, m[1], m[0]);
      chk(miso_oe_n, 1'b1);
      a = 8'($random(seed));
      b = 8'($random(seed));
      wr(a);
      u_peer.mxfer(b, got);
      repeat (6) @(negedge clk);
      chk(got, a);
      chk({rx_data, done_f, rxf}, {b, 2'b11});
      u_peer.mxfer(~b, got);
      repeat (6) @(negedge clk);
      chk({rx_data, ovr_f}, {b, 1'b1});
      ctl(4'h9, 1'b1);
    end
    // Three-wire slave: select ignored, counter restarts only on re-enable
    cfg(1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1);
    cfg(1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1);
    chk(miso_oe_n, 1'b0);
    a = 8'($random(seed));
    b = 8'($random(seed));
    wr(a);
    u_peer.mxfer(b, got);
    repeat (6) @(negedge clk);
    chk({got, rx_data, done_f, rxf}, {a, b, 2'b11});
    results();
  end
endmodule
`default_nettype wire
